// ===== hw/pcrc_defines.vh
// Purpose: constants of the programmable crc generator
// Assumes: included by hw/pcrc_top.v
// Notes: byte offsets on the axi4-lite register bus
`ifndef PCRC_DEFINES_VH
`define PCRC_DEFINES_VH
// register byte offsets
`define PCRC_OFS_CONTROL_ONE 5'h00
`define PCRC_OFS_CONTROL_TWO 5'h04
`define PCRC_OFS_POLY_LOW 5'h08
`define PCRC_OFS_POLY_HIGH 5'h0C
`define PCRC_OFS_INPUT_LOW 5'h10
`define PCRC_OFS_INPUT_HIGH 5'h14
`define PCRC_OFS_RESULT_LOW 5'h18
`define PCRC_OFS_RESULT_HIGH 5'h1C
// control one field positions
`define PCRC_BIT_MODULE_ON 15
`define PCRC_BIT_IDLE_STOP 13
`define PCRC_POS_COUNT 8
`define PCRC_BIT_FULL 7
`define PCRC_BIT_EMPTY 6
`define PCRC_BIT_IRQ_SEL 5
`define PCRC_BIT_RUN 4
`define PCRC_BIT_LSB_FIRST 3
// control two field positions
`define PCRC_POS_DATA_WIDTH 8
`define PCRC_POS_POLY_LEN 0
// reset values
`define PCRC_RST_FIELD 5'h00
`define PCRC_RST_WORD16 16'h0000
`define PCRC_RST_WORD32 32'h00000000
// fifo depths per width range
`define PCRC_DEPTH_WIDE 5'h04
`define PCRC_DEPTH_MID 5'h08
`define PCRC_DEPTH_NARROW 5'h10
// axi responses
`define PCRC_RESP_OKAY 2'h0
`define PCRC_RESP_DECERR 2'h3
`endif

// ===== hw/pcrc_top.v
// Purpose: programmable crc generator, up to 32-bit polynomial, 1..32 bit words
// Assumes: one aclk cycle is one instruction cycle; axi4-lite software access
// Notes: 16-bit registers sit in the low half of each 32-bit word
//
// Contract
// - length field is polynomial length minus one
// - set term bits enable feedback; bit zero implied
// - length 32 implies the top term
// - word width 1..32, field holds width minus one
// - fifo depth 4, 8 or 16 by width
// - byte writes; unused upper bits ignored
// - count rises on byte holding word msb
// - shift only when running and words waiting; the code still finishes a popped word after run clears
// - pop word, shift two bits per cycle
// - full flag when count reaches depth
// - empty flag when count zero, reset one
// - module off clears fifo, engine, data registers
// - direction picks msb or lsb first
// - select zero interrupts on count one to zero
// - select one interrupts on hardware run clear
// - result final (length+1)/2 cycles after drain
// - hardware clears run bit at completion
// - idle stop halts the shift engine during idle; bus and fifo keep working
`timescale 1ns/1ps
`include "pcrc_defines.vh"
module pcrc_top (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // system state
  input wire idle_mode,
  // write address channel
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // write data channel
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // write response channel
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // read address channel
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // read data channel
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // event
  output reg crc_irq_ff
);
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_SHIFT = 2'b01;
  localparam [1:0] ST_TAIL = 2'b10;

  // control and configuration
  reg module_on_ff;
  reg idle_stop_ff;
  reg irq_select_ff;
  reg run_bit_ff;
  reg lsb_first_select_ff;
  reg [4:0] data_width_field_ff;
  reg [4:0] poly_length_field_ff;
  reg [15:0] poly_terms_low_ff;
  reg [15:0] poly_terms_high_ff;
  // data path
  reg [15:0] input_low_ff;
  reg [15:0] input_high_ff;
  reg [31:0] result_ff;
  reg [31:0] fifo_mem [0:15];
  reg [3:0] wr_ptr_ff;
  reg [3:0] rd_ptr_ff;
  reg [4:0] valid_word_count_ff;
  reg [31:0] shift_buf_ff;
  reg [5:0] bits_left_ff;
  reg [4:0] tail_ff;
  reg [1:0] state_ff;

  // derived configuration
  wire halt = idle_stop_ff & idle_mode;
  wire [31:0] poly_vec = {poly_terms_high_ff, poly_terms_low_ff[15:1], 1'b1};
  wire [31:0] word_mask = 32'hFFFFFFFF >> (5'd31 - data_width_field_ff);
  wire [5:0] word_bits = {1'b0, data_width_field_ff} + 6'd1;
  wire [1:0] msb_byte = data_width_field_ff[4:3];
  wire [4:0] depth = (data_width_field_ff > 5'h0F) ? `PCRC_DEPTH_WIDE :
    ((data_width_field_ff > 5'h07) ? `PCRC_DEPTH_MID : `PCRC_DEPTH_NARROW);
  wire [5:0] tail_sum = {1'b0, poly_length_field_ff} + 6'h01;
  wire fifo_full_flag = (valid_word_count_ff == depth);
  wire fifo_empty_flag = (valid_word_count_ff == 5'h00);

  // one feedback step; truncation to the length supplies the top term
  function [31:0] crc_step;
    input [31:0] c;
    input d;
    input [31:0] p;
    input [4:0] pl;
    reg fb;
    reg [31:0] n;
    begin
      fb = d ^ c[pl];
      n = c << 1;
      if (fb)
        n = n ^ p;
      crc_step = n & (32'hFFFFFFFF >> (5'd31 - pl));
    end
  endfunction

  // axi write decode
  wire wr_fire = s_axi_awready & s_axi_awvalid & s_axi_wready & s_axi_wvalid;
  wire rd_fire = s_axi_arready & s_axi_arvalid;
  wire wr_map = (s_axi_awaddr[1:0] == 2'b00);
  wire wr_lo = wr_fire & wr_map & s_axi_wstrb[0];
  wire wr_hi = wr_fire & wr_map & s_axi_wstrb[1];
  wire wr_c1_lo = wr_lo & (s_axi_awaddr == `PCRC_OFS_CONTROL_ONE);
  wire wr_c1_hi = wr_hi & (s_axi_awaddr == `PCRC_OFS_CONTROL_ONE);
  wire wr_c2_lo = wr_lo & (s_axi_awaddr == `PCRC_OFS_CONTROL_TWO);
  wire wr_c2_hi = wr_hi & (s_axi_awaddr == `PCRC_OFS_CONTROL_TWO);
  wire sel_in_lo = (s_axi_awaddr == `PCRC_OFS_INPUT_LOW);
  wire sel_in_hi = (s_axi_awaddr == `PCRC_OFS_INPUT_HIGH);
  wire sel_res_lo = (s_axi_awaddr == `PCRC_OFS_RESULT_LOW);
  wire sel_res_hi = (s_axi_awaddr == `PCRC_OFS_RESULT_HIGH);

  // staged input with the bytes of this write merged in
  reg [15:0] nxt_input_low;
  reg [15:0] nxt_input_high;
  reg push_req;
  always @*
  begin
    nxt_input_low = input_low_ff;
    nxt_input_high = input_high_ff;
    push_req = 1'b0;
    if (wr_lo & sel_in_lo)
      nxt_input_low[7:0] = s_axi_wdata[7:0];
    if (wr_hi & sel_in_lo)
      nxt_input_low[15:8] = s_axi_wdata[15:8];
    if (wr_lo & sel_in_hi)
      nxt_input_high[7:0] = s_axi_wdata[7:0];
    if (wr_hi & sel_in_hi)
      nxt_input_high[15:8] = s_axi_wdata[15:8];
    case (msb_byte)
      2'd0: push_req = wr_lo & sel_in_lo;
      2'd1: push_req = wr_hi & sel_in_lo;
      2'd2: push_req = wr_lo & sel_in_hi;
      default: push_req = wr_hi & sel_in_hi;
    endcase
  end
  // a word written into a full fifo is dropped
  wire push = push_req & module_on_ff & ~fifo_full_flag;
  wire [31:0] push_word = {nxt_input_high, nxt_input_low} & word_mask;

  // engine next state
  reg [1:0] nxt_state;
  reg [31:0] nxt_result;
  reg [31:0] nxt_shift_buf;
  reg [5:0] nxt_bits_left;
  reg [4:0] nxt_tail;
  reg pop;
  reg hw_done;
  reg [5:0] idx0;
  reg [5:0] idx1;
  always @*
  begin
    nxt_state = state_ff;
    nxt_result = result_ff;
    nxt_shift_buf = shift_buf_ff;
    nxt_bits_left = bits_left_ff;
    nxt_tail = tail_ff;
    pop = 1'b0;
    hw_done = 1'b0;
    idx0 = 6'd0;
    idx1 = 6'd0;
    if (!halt)
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (run_bit_ff && valid_word_count_ff != 5'h00)
          begin
            pop = 1'b1;
            nxt_shift_buf = fifo_mem[rd_ptr_ff];
            nxt_bits_left = word_bits;
            nxt_state = ST_SHIFT;
          end
          else if (run_bit_ff)
          begin
            nxt_tail = tail_sum[5:1];
            nxt_state = ST_TAIL;
          end
        end
        ST_SHIFT:
        begin
          idx0 = lsb_first_select_ff ? (word_bits - bits_left_ff) : (bits_left_ff - 6'h01);
          idx1 = lsb_first_select_ff ? (idx0 + 6'h01) : (idx0 - 6'h01);
          nxt_result = crc_step(result_ff, shift_buf_ff[idx0[4:0]], poly_vec, poly_length_field_ff);
          // an odd width ends on a single step
          if (bits_left_ff >= 6'h02)
            nxt_result = crc_step(nxt_result, shift_buf_ff[idx1[4:0]], poly_vec, poly_length_field_ff);
          nxt_bits_left = (bits_left_ff >= 6'h02) ? (bits_left_ff - 6'h02) : 6'h00;
          if (bits_left_ff <= 6'd2)
            nxt_state = ST_IDLE;
        end
        ST_TAIL:
        begin
          if (!run_bit_ff)
            nxt_state = ST_IDLE;
          else if (tail_ff == 5'h00)
          begin
            hw_done = 1'b1;
            nxt_state = ST_IDLE;
          end
          else
            nxt_tail = tail_ff - 5'd1;
        end
        default: nxt_state = ST_IDLE;
      endcase
    end
  end

  wire [4:0] nxt_count = valid_word_count_ff + {4'h0, push} - {4'h0, pop};

  // register file, fifo and engine
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      module_on_ff <= 1'b0;
      idle_stop_ff <= 1'b0;
      irq_select_ff <= 1'b0;
      run_bit_ff <= 1'b0;
      lsb_first_select_ff <= 1'b0;
      data_width_field_ff <= `PCRC_RST_FIELD;
      poly_length_field_ff <= `PCRC_RST_FIELD;
      poly_terms_low_ff <= `PCRC_RST_WORD16;
      poly_terms_high_ff <= `PCRC_RST_WORD16;
      input_low_ff <= `PCRC_RST_WORD16;
      input_high_ff <= `PCRC_RST_WORD16;
      result_ff <= `PCRC_RST_WORD32;
      wr_ptr_ff <= 4'h0;
      rd_ptr_ff <= 4'h0;
      valid_word_count_ff <= 5'h00;
      shift_buf_ff <= `PCRC_RST_WORD32;
      bits_left_ff <= 6'd0;
      tail_ff <= 5'h00;
      state_ff <= ST_IDLE;
      crc_irq_ff <= 1'b0;
    end
    else
    begin
      // configuration survives module off
      if (wr_c1_hi)
        {module_on_ff, idle_stop_ff} <= {s_axi_wdata[`PCRC_BIT_MODULE_ON], s_axi_wdata[`PCRC_BIT_IDLE_STOP]};
      if (wr_c1_lo)
        {irq_select_ff, lsb_first_select_ff} <= {s_axi_wdata[`PCRC_BIT_IRQ_SEL], s_axi_wdata[`PCRC_BIT_LSB_FIRST]};
      if (wr_c2_hi)
        data_width_field_ff <= s_axi_wdata[`PCRC_POS_DATA_WIDTH +: 5];
      if (wr_c2_lo)
        poly_length_field_ff <= s_axi_wdata[`PCRC_POS_POLY_LEN +: 5];
      if (wr_lo & (s_axi_awaddr == `PCRC_OFS_POLY_LOW))
        poly_terms_low_ff[7:0] <= {s_axi_wdata[7:1], 1'b0};
      if (wr_hi & (s_axi_awaddr == `PCRC_OFS_POLY_LOW))
        poly_terms_low_ff[15:8] <= s_axi_wdata[15:8];
      if (wr_lo & (s_axi_awaddr == `PCRC_OFS_POLY_HIGH))
        poly_terms_high_ff[7:0] <= s_axi_wdata[7:0];
      if (wr_hi & (s_axi_awaddr == `PCRC_OFS_POLY_HIGH))
        poly_terms_high_ff[15:8] <= s_axi_wdata[15:8];
      // software write of run wins over the hardware clear
      if (wr_c1_lo)
        run_bit_ff <= s_axi_wdata[`PCRC_BIT_RUN];
      else if (hw_done)
        run_bit_ff <= 1'b0;
      crc_irq_ff <= 1'b0;
      if (!module_on_ff)
      begin
        input_low_ff <= `PCRC_RST_WORD16;
        input_high_ff <= `PCRC_RST_WORD16;
        result_ff <= `PCRC_RST_WORD32;
        wr_ptr_ff <= 4'h0;
        rd_ptr_ff <= 4'h0;
        valid_word_count_ff <= 5'h00;
        shift_buf_ff <= `PCRC_RST_WORD32;
        bits_left_ff <= 6'd0;
        tail_ff <= 5'h00;
        state_ff <= ST_IDLE;
      end
      else
      begin
        input_low_ff <= nxt_input_low;
        input_high_ff <= nxt_input_high;
        if (push)
        begin
          fifo_mem[wr_ptr_ff] <= push_word;
          wr_ptr_ff <= wr_ptr_ff + 4'h1;
        end
        if (pop)
          rd_ptr_ff <= rd_ptr_ff + 4'h1;
        valid_word_count_ff <= nxt_count;
        shift_buf_ff <= nxt_shift_buf;
        bits_left_ff <= nxt_bits_left;
        tail_ff <= nxt_tail;
        state_ff <= nxt_state;
        // software load of the result beats the engine
        result_ff <= nxt_result;
        if (wr_lo & sel_res_lo)
          result_ff[7:0] <= s_axi_wdata[7:0];
        if (wr_hi & sel_res_lo)
          result_ff[15:8] <= s_axi_wdata[15:8];
        if (wr_lo & sel_res_hi)
          result_ff[23:16] <= s_axi_wdata[7:0];
        if (wr_hi & sel_res_hi)
          result_ff[31:24] <= s_axi_wdata[15:8];
        if (!irq_select_ff && valid_word_count_ff == 5'd1 && nxt_count == 5'h00)
          crc_irq_ff <= 1'b1;
        if (irq_select_ff && hw_done && !wr_c1_lo)
          crc_irq_ff <= 1'b1;
      end
    end
  end

  // readback
  reg [15:0] rd_val;
  reg rd_hit;
  always @*
  begin
    rd_hit = (s_axi_araddr[1:0] == 2'b00);
    rd_val = 16'h0000;
    case (s_axi_araddr)
      `PCRC_OFS_CONTROL_ONE:
      begin
        rd_val[`PCRC_BIT_MODULE_ON] = module_on_ff;
        rd_val[`PCRC_BIT_IDLE_STOP] = idle_stop_ff;
        rd_val[`PCRC_POS_COUNT +: 5] = valid_word_count_ff;
        rd_val[`PCRC_BIT_FULL] = fifo_full_flag;
        rd_val[`PCRC_BIT_EMPTY] = fifo_empty_flag;
        rd_val[`PCRC_BIT_IRQ_SEL] = irq_select_ff;
        rd_val[`PCRC_BIT_RUN] = run_bit_ff;
        rd_val[`PCRC_BIT_LSB_FIRST] = lsb_first_select_ff;
      end
      `PCRC_OFS_CONTROL_TWO:
      begin
        rd_val[`PCRC_POS_DATA_WIDTH +: 5] = data_width_field_ff;
        rd_val[`PCRC_POS_POLY_LEN +: 5] = poly_length_field_ff;
      end
      `PCRC_OFS_POLY_LOW: rd_val = poly_terms_low_ff;
      `PCRC_OFS_POLY_HIGH: rd_val = poly_terms_high_ff;
      `PCRC_OFS_INPUT_LOW: rd_val = input_low_ff;
      `PCRC_OFS_INPUT_HIGH: rd_val = input_high_ff;
      `PCRC_OFS_RESULT_LOW: rd_val = result_ff[15:0];
      `PCRC_OFS_RESULT_HIGH: rd_val = result_ff[31:16];
      default: rd_hit = 1'b0;
    endcase
  end

  // axi4-lite handshakes: address and data taken together
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PCRC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `PCRC_RESP_OKAY;
      s_axi_rdata <= `PCRC_RST_WORD32;
    end
    else
    begin
      s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `PCRC_RESP_OKAY : `PCRC_RESP_DECERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0000, rd_val};
        s_axi_rresp <= rd_hit ? `PCRC_RESP_OKAY : `PCRC_RESP_DECERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule // pcrc_top

// ===== sim/pcrc_assertions.sv
// Purpose: port-level checks of the crc generator
// Assumes: single aclk domain, aresetn synchronous active low
// Notes: register reads decoded from the last accepted read address
`timescale 1ns/1ps
`include "pcrc_defines.vh"
module pcrc_assertions (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // write side
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  // read side
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // event
  input wire crc_irq_ff
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  reg [4:0] rd_addr_ff;
  wire rd_one = s_axi_rvalid && (rd_addr_ff == `PCRC_OFS_CONTROL_ONE);
  // one read in flight, so the captured address names the data
  always @(posedge aclk)
  begin
    if (!aresetn)
      rd_addr_ff <= 5'h00;
    else if (s_axi_arvalid && s_axi_arready)
      rd_addr_ff <= s_axi_araddr;
  end
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_ANSWER: assert property (wr_taken |=> s_axi_bvalid)
    else $error("write response late");
  AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_IRQ_PULSE: assert property (crc_irq_ff |=> !crc_irq_ff)
    else $error("interrupt longer than a cycle");
  AST_EMPTY_FLAG: assert property (rd_one |-> s_axi_rdata[6] == (s_axi_rdata[12:8] == 5'h00))
    else $error("empty flag disagrees with count");
  AST_FULL_FLAG: assert property (rd_one && s_axi_rdata[7] |-> s_axi_rdata[12:8] inside {5'h04, 5'h08, 5'h10})
    else $error("full flag at odd count");
  AST_COUNT_MAX: assert property (rd_one |-> s_axi_rdata[12:8] <= 5'h10)
    else $error("count above deepest fifo");
  AST_POLY_BIT0: assert property (s_axi_rvalid && rd_addr_ff == `PCRC_OFS_POLY_LOW |-> !s_axi_rdata[0])
    else $error("poly bit zero reads set");
  AST_CTL2_SPARE: assert property (s_axi_rvalid && rd_addr_ff == `PCRC_OFS_CONTROL_TWO |->
    s_axi_rdata[15:13] == 3'h0 && s_axi_rdata[7:5] == 3'h0)
    else $error("control two spare bits set");
endmodule // pcrc_assertions
bind pcrc_top pcrc_assertions i_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .crc_irq_ff(crc_irq_ff));

// ===== sim/pcrc_tb_top.sv
// Purpose: self-checking bench for the crc generator
// Assumes: bus answers when it likes; bench waits under a cycle ceiling
// Notes: crc reference computed bit by bit here
`timescale 1ns/1ps
`include "pcrc_defines.vh"
module pcrc_tb_top;
  localparam [4:0] C1 = `PCRC_OFS_CONTROL_ONE;
  localparam [4:0] C2 = `PCRC_OFS_CONTROL_TWO;
  localparam [4:0] PL = `PCRC_OFS_POLY_LOW;
  localparam [4:0] PH = `PCRC_OFS_POLY_HIGH;
  localparam [4:0] IL = `PCRC_OFS_INPUT_LOW;
  localparam [4:0] IH = `PCRC_OFS_INPUT_HIGH;
  localparam [4:0] RL = `PCRC_OFS_RESULT_LOW;
  localparam [4:0] RH = `PCRC_OFS_RESULT_HIGH;
  reg aclk, aresetn, idle_mode, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg [4:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata;
  reg [3:0] s_axi_wstrb;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, crc_irq_ff;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer fails, check_count, cyc, irq_cnt, i;
  reg [1:0] resp;
  reg [15:0] rv;
  pcrc_top i_dut (.aclk(aclk), .aresetn(aresetn), .idle_mode(idle_mode),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .crc_irq_ff(crc_irq_ff));
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (crc_irq_ff === 1'b1)
      irq_cnt <= irq_cnt + 1;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      report_and_stop;
    end
  end
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e)
      begin
        fails = fails + 1;
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // ready sampled 1ns after the edge is the value seen at the next edge
  task wr(input [4:0] a, input [15:0] d, input [3:0] s);
    reg aw_t, w_t, b_t;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      b_t = 1'b0;
      while (!b_t)
      begin
        #1;
        aw_t = s_axi_awready;
        w_t = s_axi_wready;
        b_t = s_axi_bvalid;
        resp = s_axi_bresp;
        @(posedge aclk);
        if (aw_t) s_axi_awvalid <= 1'b0;
        if (w_t) s_axi_wvalid <= 1'b0;
        if (b_t) s_axi_bready <= 1'b0;
      end
    end
  endtask
  task rd(input [4:0] a);
    reg ar_t, r_t;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      r_t = 1'b0;
      while (!r_t)
      begin
        #1;
        ar_t = s_axi_arready;
        r_t = s_axi_rvalid;
        rv = s_axi_rdata[15:0];
        resp = s_axi_rresp;
        @(posedge aclk);
        if (ar_t) s_axi_arvalid <= 1'b0;
        if (r_t) s_axi_rready <= 1'b0;
      end
    end
  endtask
  // top term falls out of the mask, so it is implied at any length
  function [31:0] ref_crc(input [31:0] c, input [31:0] d, input [4:0] dw, input [4:0] pl, input [31:0] p,
    input lsb);
    integer k;
    reg fb;
    begin
      for (k = 0; k <= dw; k = k + 1)
      begin
        fb = (lsb ? d[k] : d[dw - k]) ^ c[pl];
        c = c << 1;
        if (fb) c = c ^ (p | 32'h00000001);
      end
      ref_crc = (pl == 5'h1F) ? c : c & ((32'h00000001 << (pl + 5'h01)) - 32'h00000001);
    end
  endfunction
  task push(input [4:0] dw, input [31:0] w);
    begin
      wr(IL, w[15:0], (dw < 5'h08) ? 4'h1 : 4'h3);
      if (dw > 5'h0F) wr(IH, w[31:16], 4'h3);
    end
  endtask
  task reset_case;
    begin
      rd(C1);
      chk("control one at reset", 32'h00000040, rv);
      for (i = 1; i < 8; i = i + 1)
      begin
        rd({i[2:0], 2'h0});
        chk("register at reset", 32'h00000000, rv);
      end
      rd(5'h02);
      chk("unaligned read response", `PCRC_RESP_DECERR, resp);
      wr(5'h03, 16'hFFFF, 4'h3);
      chk("unaligned write response", `PCRC_RESP_DECERR, resp);
      wr(C1, 16'h1FC0, 4'h3);
      rd(C1);
      chk("status bits read only", 32'h00000040, rv);
      wr(PL, 16'hFFFF, 4'h3);
      rd(PL);
      chk("poly low readback", 32'h0000FFFE, rv);
    end
  endtask
  task fill_case(input [4:0] dw, input [4:0] depth);
    begin
      wr(C1, 16'h8000, 4'h3);
      wr(C2, {3'h0, dw, 8'h0F}, 4'h3);
      wr(IL, 16'h0055, (dw < 5'h08) ? 4'h1 : 4'h3);
      rd(C1);
      chk("count after low half", (dw > 5'h0F) ? 0 : 1, rv[12:8]);
      if (dw > 5'h0F) wr(IH, 16'h0055, 4'h3);
      repeat (depth) push(dw, 32'h00AA00AA);
      rd(C1);
      chk("count when full", depth, rv[12:8]);
      chk("full and empty flags", 2'h2, rv[7:6]);
      wr(RL, 16'h1234, 4'h3);
      wr(C1, 16'h0000, 4'h3);
      rd(C1);
      chk("control one when off", 32'h00000040, rv);
      rd(RL);
      chk("result when off", 32'h00000000, rv);
      rd(C2);
      chk("control two kept", {3'h0, dw, 8'h0F}, rv);
    end
  endtask
  task crc_case(input [4:0] dw, input [4:0] pl, input [31:0] poly, input lsb, input sel, input [31:0] w0,
    input [31:0] w1);
    reg [15:0] ctl;
    reg [15:0] lo;
    integer base;
    begin
      ctl = {1'b1, 9'h000, sel, 1'b0, lsb, 3'h0};
      wr(C1, 16'h8000, 4'h3);
      wr(C2, {3'h0, dw, 3'h0, pl}, 4'h3);
      wr(PL, poly[15:0], 4'h3);
      wr(PH, poly[31:16], 4'h3);
      wr(C1, ctl, 4'h3);
      push(dw, w0);
      push(dw, w1);
      wr(RL, 16'h0000, 4'h3);
      wr(RH, 16'h0000, 4'h3);
      base = irq_cnt;
      wr(C1, ctl | 16'h0010, 4'h3);
      rv = 16'h0010;
      while (rv[4]) rd(C1);
      chk("interrupts per run", 1, irq_cnt - base);
      rd(RL);
      lo = rv;
      rd(RH);
      chk("crc result", ref_crc(ref_crc(0, w0, dw, pl, poly, lsb), w1, dw, pl, poly, lsb), {rv, lo});
      wr(C1, 16'h0000, 4'h3);
    end
  endtask
  // idle halt must freeze the engine with a word still waiting
  task idle_case;
    begin
      wr(C1, 16'hA000, 4'h3);
      wr(C2, 16'h070F, 4'h3);
      push(5'h07, 32'h0000005A);
      idle_mode <= 1'b1;
      wr(C1, 16'hA010, 4'h3);
      repeat (40) @(posedge aclk);
      rd(C1);
      chk("halted in idle", 32'h0000A110, rv);
      idle_mode <= 1'b0;
      while (rv[4]) rd(C1);
      chk("resumed and done", 32'h0000A040, rv);
    end
  endtask
  initial
  begin
    fails = 0;
    check_count = 0;
    cyc = 0;
    irq_cnt = 0;
    {aresetn, idle_mode, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
    s_axi_awaddr = 5'h00;
    s_axi_araddr = 5'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    reset_case;
    fill_case(5'h10, 5'h04);
    fill_case(5'h0F, 5'h08);
    fill_case(5'h08, 5'h08);
    fill_case(5'h07, 5'h10);
    crc_case(5'h07, 5'h0F, 32'h00001021, 1'b0, 1'b0, 32'h31, 32'hA5);
    crc_case(5'h07, 5'h0F, 32'h00001021, 1'b1, 1'b1, 32'h31, 32'hA5);
    crc_case(5'h1F, 5'h1F, 32'h04C11DB6, 1'b0, 1'b1, 32'h12345678, 32'hCAFEF00D);
    crc_case(5'h05, 5'h04, 32'h00000014, 1'b0, 1'b0, 32'hFF, 32'hC3);
    // idle without idle stop must not slow the engine
    idle_mode <= 1'b1;
    crc_case(5'h14, 5'h07, 32'h00000006, 1'b1, 1'b0, 32'hABCDE, 32'h12345);
    idle_mode <= 1'b0;
    idle_case;
    report_and_stop;
  end
endmodule // pcrc_tb_top
